// File: rpf_consts.vh
// Purpose: register offsets, field positions, reset values and timing counts
// Assumes: apb byte addresses, one aligned word per 8-bit register
// Notes:   definitions only
`ifndef RPF_CONSTS_VH
`define RPF_CONSTS_VH

`define RPF_ADDR_PKT_OPT_A     12'h000
`define RPF_ADDR_PKT_CODING    12'h004
`define RPF_ADDR_WHITEN_CTL    12'h008
`define RPF_ADDR_TX_LEN        12'h00c
`define RPF_ADDR_RX_LEN        12'h010
`define RPF_ADDR_RX_ID_DLY     12'h014
`define RPF_ADDR_HDR_ADDR      12'h018
`define RPF_ADDR_HDR_EXT_ADDR  12'h01c
`define RPF_ADDR_RATE_DIV_LO   12'h020
`define RPF_ADDR_FOFS_HI       12'h024
`define RPF_ADDR_FOFS_LO       12'h028
`define RPF_ADDR_DEMOD_DIV     12'h02c
`define RPF_ADDR_DECIM         12'h030
`define RPF_ADDR_FILT_DEV      12'h034
`define RPF_ADDR_OFS_PHASE     12'h038
`define RPF_ADDR_DET_THR       12'h03c
`define RPF_ADDR_OFS_RATIO     12'h040
`define RPF_ADDR_EXT_CTL       12'h044
`define RPF_ADDR_RX_STATUS     12'h048

`define RPF_RST_PKT_OPT_A      8'h24
`define RPF_RST_PKT_CODING     8'h20
`define RPF_RST_WHITEN_CTL     8'h36
`define RPF_RST_TX_LEN         8'h40
`define RPF_RST_RX_LEN         8'h40
`define RPF_RST_RX_ID_DLY      8'h20
`define RPF_RST_HDR_ADDR       8'h00
`define RPF_RST_HDR_EXT_ADDR   8'h00
`define RPF_RST_RATE_DIV_LO    8'h01
`define RPF_RST_FOFS_HI        8'h90
`define RPF_RST_FOFS_LO        8'h9a
`define RPF_RST_DEMOD_DIV      8'h03
`define RPF_RST_DECIM          8'h00
`define RPF_RST_FILT_DEV       8'he0
`define RPF_RST_OFS_PHASE      8'h08
`define RPF_RST_DET_THR        8'h30
`define RPF_RST_OFS_RATIO      8'h40
`define RPF_RST_EXT_CTL        8'h00

// writable masks, reserved bits read zero
`define RPF_MASK_PKT_OPT_A     8'hfc
`define RPF_MASK_RX_ID_DLY     8'h3f
`define RPF_MASK_HDR_ADDR      8'h3f
`define RPF_MASK_FOFS_HI       8'hfd
`define RPF_MASK_DIV6          8'h3f
`define RPF_MASK_FILT_DEV      8'hfe
`define RPF_MASK_OFS_PHASE     8'h0a
`define RPF_MASK_EXT_CTL       8'h07

// packet_options_a fields
`define RPF_TAG_HI             7
`define RPF_TAG_LO             6
`define RPF_TRAILER_BIT        5
`define RPF_FMT0_BIT           4
`define RPF_SYNC_HI            3
`define RPF_SYNC_LO            2
// packet_coding_options fields
`define RPF_MANCH_BIT          7
`define RPF_FEC_BIT            6
`define RPF_CRC_BIT            5
`define RPF_CHECK_POLY_SELECT_BIT         4
`define RPF_LENFLD_BIT         3
`define RPF_ADDRCHK_BIT        2
`define RPF_HDRSIZE_BIT        1
`define RPF_HDRON_BIT          0
// whitening_control fields
`define RPF_SCRAMBLE_BIT       7
// offset_and_phase_modes fields
`define RPF_DOMAIN_BIT         3
`define RPF_PHASE_BIT          1
// ext_control: bit0 fmt1, bit1 sync low bit, bit2 seed bit 7; bit3 seed bit 8 pair
`define RPF_EXT_FMT1_BIT       0
`define RPF_EXT_SYNCLB_BIT     1
`define RPF_EXT_SEED7_BIT      2

// timing, microseconds at 50 MHz
`define RPF_CLK_MHZ            50
`define RPF_US_TO_CYC(us)      ((us) * `RPF_CLK_MHZ)

`endif

// File: rpf_delay_timer.v
// Purpose: one-shot delay counter for rx settle and tx start windows
// Assumes: start is a one-cycle pulse, cycles is held while busy
// Notes:   zero cycles finishes on the cycle after start
`timescale 1ns/1ps
module rpf_delay_timer #(
  parameter W = 13
) (
  input  wire         clk,
  input  wire         reset_n,
  input  wire         start,
  input  wire [W-1:0] cycles,
  output reg          busy_ff,
  output reg          done_ff
);
  reg [W-1:0] cnt_ff;

  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      cnt_ff  <= {W{1'b0}};
      busy_ff <= 1'b0;
      done_ff <= 1'b0;
    end else begin
      done_ff <= 1'b0;
      if (start) begin
        cnt_ff  <= cycles;
        busy_ff <= 1'b1;
      end else if (busy_ff) begin
        if (cnt_ff == {W{1'b0}}) begin
          busy_ff <= 1'b0;
          done_ff <= 1'b1;
        end else begin
          cnt_ff <= cnt_ff - {{(W-1){1'b0}}, 1'b1};
        end
      end
    end
  end
endmodule

// File: rpf_packet_format.v
// Purpose: packet format configuration registers with derived control outputs
// Assumes: apb slave, single clock, packet engine reports receive events
// Notes:   zero-wait apb; unmapped addresses read zero and raise pslverr
`timescale 1ns/1ps
`include "rpf_consts.vh"

// What this block does
// - tx tag fills header top two bits
// - two-bit scramble polynomial format select
// - sync length is three-bit value plus one
// - manchester fec crc trailer follow enables
// - crc polynomial chosen by coding select bit
// - length from register when field disabled
// - address mismatch fails packet when checking
// - header one or two bytes by size
// - zero local address skips the check
// - write sets tx address, read rx address
// - scramble on enable, nine-bit seed
// - burst tx payload size from register
// - rx length read returns fifo count
// - received tag captured, read only
// - rx settle delay selected by code
// - tx start delay selected by code
// - tx bit divider, nine bits from rate low byte and offset high bit 0
// - offset updates high then low write
// - demod clock divides by divider plus one
// - decimation clocks at divider plus one
// - phase range select half or full
// - offset correction analog or digital
module rpf_packet_format (
  input  wire        clk,
  input  wire        reset_n,
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [11:0] paddr,
  input  wire [31:0] pwdata,
  output reg  [31:0] prdata,
  output reg         pready,
  output reg         pslverr,
  input  wire        rx_enable_pulse,
  input  wire        tx_request_pulse,
  input  wire        rx_pkt_done,
  input  wire [1:0]  rx_pkt_tag,
  input  wire [5:0]  rx_pkt_addr,
  input  wire [7:0]  rx_pkt_ext_addr,
  input  wire [7:0]  rx_pkt_len,
  input  wire [7:0]  rx_fifo_count,
  output reg  [1:0]  scramble_format_ff,
  output reg  [3:0]  sync_size_ff,
  output reg         manchester_on_ff,
  output reg         error_correction_on_ff,
  output reg         crc_on_ff,
  output reg         trailer_on_ff,
  output reg  [15:0] crc_poly_ff,
  output reg         scramble_on_ff,
  output reg  [8:0]  scramble_seed_ff,
  output reg  [15:0] tx_header_ff,
  output reg         tx_header_two_bytes_ff,
  output reg         header_field_on_ff,
  output reg  [7:0]  tx_payload_bytes_ff,
  output reg  [7:0]  rx_expect_len_ff,
  output reg         rx_addr_fail_ff,
  output reg         rx_settled_ff,
  output reg         tx_start_ff,
  output reg  [8:0]  tx_bit_divider_ff,
  output reg  [11:0] rx_freq_offset_ff,
  output reg  [5:0]  demod_divider_ff,
  output reg  [5:0]  decimation_ratio_ff,
  output reg         phase_range_select_ff,
  output reg         offset_correction_domain_ff
);
  localparam TW = 13;
  localparam NREG = 18;
  localparam [7:0] FOFS_HI_RST = `RPF_RST_FOFS_HI;

  // reset, address and mask tables for the plain rw storage
  wire [8*NREG-1:0]  rst_tbl = {`RPF_RST_EXT_CTL, `RPF_RST_OFS_RATIO, `RPF_RST_DET_THR,
                               `RPF_RST_OFS_PHASE, `RPF_RST_FILT_DEV, `RPF_RST_DECIM,
                               `RPF_RST_DEMOD_DIV, `RPF_RST_FOFS_LO, `RPF_RST_FOFS_HI,
                               `RPF_RST_RATE_DIV_LO, `RPF_RST_HDR_EXT_ADDR, `RPF_RST_HDR_ADDR,
                               `RPF_RST_RX_ID_DLY, `RPF_RST_RX_LEN, `RPF_RST_TX_LEN,
                               `RPF_RST_WHITEN_CTL, `RPF_RST_PKT_CODING, `RPF_RST_PKT_OPT_A};
  wire [8*NREG-1:0]  msk_tbl = {`RPF_MASK_EXT_CTL, 8'hff, 8'hff, `RPF_MASK_OFS_PHASE,
                               `RPF_MASK_FILT_DEV, `RPF_MASK_DIV6, `RPF_MASK_DIV6, 8'hff,
                               `RPF_MASK_FOFS_HI, 8'hff, 8'hff, `RPF_MASK_HDR_ADDR,
                               `RPF_MASK_RX_ID_DLY, 8'hff, 8'hff, 8'hff, 8'hff,
                               `RPF_MASK_PKT_OPT_A};
  wire [12*NREG-1:0] adr_tbl = {`RPF_ADDR_EXT_CTL, `RPF_ADDR_OFS_RATIO, `RPF_ADDR_DET_THR,
                               `RPF_ADDR_OFS_PHASE, `RPF_ADDR_FILT_DEV, `RPF_ADDR_DECIM,
                               `RPF_ADDR_DEMOD_DIV, `RPF_ADDR_FOFS_LO, `RPF_ADDR_FOFS_HI,
                               `RPF_ADDR_RATE_DIV_LO, `RPF_ADDR_HDR_EXT_ADDR, `RPF_ADDR_HDR_ADDR,
                               `RPF_ADDR_RX_ID_DLY, `RPF_ADDR_RX_LEN, `RPF_ADDR_TX_LEN,
                               `RPF_ADDR_WHITEN_CTL, `RPF_ADDR_PKT_CODING, `RPF_ADDR_PKT_OPT_A};

  reg  [7:0]  reg_ff [0:NREG-1];
  reg  [3:0]  fofs_hi_stage_ff;
  reg  [1:0]  rx_tag_ff;
  reg  [5:0]  rx_addr_ff;
  reg         ext_seed8_ff;
  wire        wr_en = psel & penable & pwrite;
  wire        rd_setup = psel & ~penable & ~pwrite;
  wire [NREG-1:0] hit;

  genvar gi;
  generate
    for (gi = 0; gi < NREG; gi = gi + 1) begin : g_reg
      assign hit[gi] = (paddr == adr_tbl[12*gi +: 12]);
      always @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
          reg_ff[gi] <= rst_tbl[8*gi +: 8];
        end else if (wr_en && hit[gi]) begin
          reg_ff[gi] <= pwdata[7:0] & msk_tbl[8*gi +: 8];
        end
      end
    end
  endgenerate

  wire [7:0] opt_a   = reg_ff[0];
  wire [7:0] coding  = reg_ff[1];
  wire [7:0] whiten  = reg_ff[2];
  wire [7:0] id_dly  = reg_ff[5];
  wire [7:0] ext_ctl = reg_ff[17];
  wire       mapped  = |hit | (paddr == `RPF_ADDR_RX_STATUS);

  // high nibble staged until low byte is written
  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      fofs_hi_stage_ff <= FOFS_HI_RST[7:4];
    end else if (wr_en && hit[9]) begin
      fofs_hi_stage_ff <= pwdata[7:4];
    end
  end

  // received tag and address captured from the link only
  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      rx_tag_ff    <= 2'h0;
      rx_addr_ff   <= 6'h00;
      ext_seed8_ff <= 1'b0;
    end else begin
      if (rx_pkt_done) begin
        rx_tag_ff  <= rx_pkt_tag;
        rx_addr_ff <= rx_pkt_addr;
      end
      if (wr_en && hit[17]) begin
        ext_seed8_ff <= pwdata[3];
      end
    end
  end

  // read mux
  reg [7:0] rd_byte;
  always @* begin
    rd_byte = 8'h00;
    if (paddr == `RPF_ADDR_RX_LEN) begin
      // read shows fifo count, not setting
      rd_byte = rx_fifo_count;
    end else if (paddr == `RPF_ADDR_RX_ID_DLY) begin
      rd_byte = {rx_tag_ff, id_dly[5:0]};
    end else if (paddr == `RPF_ADDR_HDR_ADDR) begin
      rd_byte = {2'b00, rx_addr_ff};
    end else if (paddr == `RPF_ADDR_EXT_CTL) begin
      rd_byte = {4'h0, ext_seed8_ff, ext_ctl[2:0]};
    end else if (paddr == `RPF_ADDR_RX_STATUS) begin
      rd_byte = {5'h00, rx_addr_fail_ff, rx_settled_ff, tx_start_ff};
    end else if (paddr == `RPF_ADDR_PKT_OPT_A) begin
      rd_byte = opt_a;
    end else if (paddr == `RPF_ADDR_PKT_CODING) begin
      rd_byte = coding;
    end else if (paddr == `RPF_ADDR_WHITEN_CTL) begin
      rd_byte = whiten;
    end else if (paddr == `RPF_ADDR_TX_LEN) begin
      rd_byte = reg_ff[3];
    end else if (paddr == `RPF_ADDR_HDR_EXT_ADDR) begin
      rd_byte = reg_ff[7];
    end else if (paddr == `RPF_ADDR_RATE_DIV_LO) begin
      rd_byte = reg_ff[8];
    end else if (paddr == `RPF_ADDR_FOFS_HI) begin
      rd_byte = reg_ff[9];
    end else if (paddr == `RPF_ADDR_FOFS_LO) begin
      rd_byte = reg_ff[10];
    end else if (paddr == `RPF_ADDR_DEMOD_DIV) begin
      rd_byte = reg_ff[11];
    end else if (paddr == `RPF_ADDR_DECIM) begin
      rd_byte = reg_ff[12];
    end else if (paddr == `RPF_ADDR_FILT_DEV) begin
      rd_byte = reg_ff[13];
    end else if (paddr == `RPF_ADDR_OFS_PHASE) begin
      rd_byte = reg_ff[14];
    end else if (paddr == `RPF_ADDR_DET_THR) begin
      rd_byte = reg_ff[15];
    end else if (paddr == `RPF_ADDR_OFS_RATIO) begin
      rd_byte = reg_ff[16];
    end
  end

  // apb answer: ready in the access phase, read data captured in setup
  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      prdata  <= 32'h0000_0000;
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready  <= psel & ~penable;
      pslverr <= psel & ~penable & ~mapped;
      if (rd_setup) begin
        prdata <= {24'h000000, rd_byte};
      end
    end
  end

  // settle and start delay tables in cycles
  reg [31:0] settle_cyc;
  reg [31:0] start_cyc;
  always @* begin
    case (id_dly[5:3])
      3'd0:    settle_cyc = `RPF_US_TO_CYC(4);
      3'd1:    settle_cyc = `RPF_US_TO_CYC(8);
      3'd2:    settle_cyc = `RPF_US_TO_CYC(12);
      3'd3:    settle_cyc = `RPF_US_TO_CYC(16);
      3'd4:    settle_cyc = `RPF_US_TO_CYC(20);
      3'd5:    settle_cyc = `RPF_US_TO_CYC(32);
      3'd6:    settle_cyc = `RPF_US_TO_CYC(64);
      default: settle_cyc = `RPF_US_TO_CYC(100);
    endcase
    case (id_dly[2:0])
      3'd0:    start_cyc = `RPF_US_TO_CYC(0);
      3'd1:    start_cyc = `RPF_US_TO_CYC(10);
      3'd2:    start_cyc = `RPF_US_TO_CYC(20);
      3'd3:    start_cyc = `RPF_US_TO_CYC(40);
      3'd4:    start_cyc = `RPF_US_TO_CYC(60);
      3'd5:    start_cyc = `RPF_US_TO_CYC(80);
      3'd6:    start_cyc = `RPF_US_TO_CYC(100);
      default: start_cyc = `RPF_US_TO_CYC(120);
    endcase
  end

  wire settle_busy;
  wire settle_done;
  wire start_busy;
  wire start_done;

  rpf_delay_timer #(.W(TW)) u_settle (
    .clk     (clk),
    .reset_n (reset_n),
    .start   (rx_enable_pulse),
    .cycles  (settle_cyc[TW-1:0]),
    .busy_ff (settle_busy),
    .done_ff (settle_done)
  );

  rpf_delay_timer #(.W(TW)) u_txstart (
    .clk     (clk),
    .reset_n (reset_n),
    .start   (tx_request_pulse),
    .cycles  (start_cyc[TW-1:0]),
    .busy_ff (start_busy),
    .done_ff (start_done)
  );

  // address match evaluated on received packet
  wire [7:0] hdr_ext = reg_ff[7];
  wire addr_eq  = (rx_pkt_addr == reg_ff[6][5:0]) &&
                  (!coding[`RPF_HDRSIZE_BIT] || rx_pkt_ext_addr == hdr_ext);
  wire addr_zero = (reg_ff[6][5:0] == 6'h00) && (!coding[`RPF_HDRSIZE_BIT] || hdr_ext == 8'h00);
  wire addr_bad  = coding[`RPF_ADDRCHK_BIT] && !addr_zero && !addr_eq;

  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      scramble_format_ff          <= 2'b00;
      sync_size_ff                <= 4'd0;
      manchester_on_ff            <= 1'b0;
      error_correction_on_ff      <= 1'b0;
      crc_on_ff                   <= 1'b0;
      trailer_on_ff               <= 1'b0;
      crc_poly_ff                 <= 16'h0000;
      scramble_on_ff              <= 1'b0;
      scramble_seed_ff            <= 9'h000;
      tx_header_ff                <= 16'h0000;
      tx_header_two_bytes_ff      <= 1'b0;
      header_field_on_ff          <= 1'b0;
      tx_payload_bytes_ff         <= 8'h00;
      rx_expect_len_ff            <= 8'h00;
      rx_addr_fail_ff             <= 1'b0;
      rx_settled_ff               <= 1'b0;
      tx_start_ff                 <= 1'b0;
      tx_bit_divider_ff           <= 9'h000;
      rx_freq_offset_ff           <= {FOFS_HI_RST[7:4], `RPF_RST_FOFS_LO};
      demod_divider_ff            <= 6'h00;
      decimation_ratio_ff         <= 6'h00;
      phase_range_select_ff       <= 1'b0;
      offset_correction_domain_ff <= 1'b0;
    end else begin
      scramble_format_ff <= {ext_ctl[`RPF_EXT_FMT1_BIT], opt_a[`RPF_FMT0_BIT]};
      sync_size_ff <= {1'b0, opt_a[`RPF_SYNC_HI:`RPF_SYNC_LO], ext_ctl[`RPF_EXT_SYNCLB_BIT]} + 4'd1;
      manchester_on_ff       <= coding[`RPF_MANCH_BIT];
      error_correction_on_ff <= coding[`RPF_FEC_BIT];
      crc_on_ff              <= coding[`RPF_CRC_BIT];
      trailer_on_ff          <= opt_a[`RPF_TRAILER_BIT];
      crc_poly_ff <= coding[`RPF_CHECK_POLY_SELECT_BIT] ? 16'h8005 : 16'h1021;
      scramble_on_ff   <= whiten[`RPF_SCRAMBLE_BIT];
      scramble_seed_ff <= {ext_seed8_ff, ext_ctl[`RPF_EXT_SEED7_BIT], whiten[6:0]};
      header_field_on_ff     <= coding[`RPF_HDRON_BIT];
      tx_header_two_bytes_ff <= coding[`RPF_HDRSIZE_BIT];
      tx_header_ff <= {opt_a[`RPF_TAG_HI:`RPF_TAG_LO], reg_ff[6][5:0],
                       coding[`RPF_HDRSIZE_BIT] ? hdr_ext : 8'h00};
      tx_payload_bytes_ff <= reg_ff[3];
      // length source
      // packet length is only valid alongside its done pulse
      rx_expect_len_ff <= !coding[`RPF_LENFLD_BIT] ? reg_ff[4] : rx_pkt_done ? rx_pkt_len : rx_expect_len_ff;
      if (rx_pkt_done) begin
        rx_addr_fail_ff <= addr_bad;
      end
      rx_settled_ff <= settle_done ? 1'b1 : (rx_enable_pulse | settle_busy) ? 1'b0 : rx_settled_ff;
      tx_start_ff   <= start_done;
      tx_bit_divider_ff <= {reg_ff[9][0], reg_ff[8]};
      if (wr_en && hit[10]) begin
        rx_freq_offset_ff <= {fofs_hi_stage_ff, pwdata[7:0]};
      end
      demod_divider_ff <= reg_ff[11][5:0];
      decimation_ratio_ff <= reg_ff[12][5:0];
      phase_range_select_ff <= reg_ff[14][`RPF_PHASE_BIT];
      offset_correction_domain_ff <= reg_ff[14][`RPF_DOMAIN_BIT];
    end
  end
endmodule

// File: rpf_packet_format_monitor.sv
// Purpose: port-level checks for the packet format register block
// Assumes: zero-wait apb, derived outputs one cycle behind their registers, offset loaded on the low write itself
// Notes:   attached to every instance by the bind below
`timescale 1ns/1ps
`include "rpf_consts.vh"
module rpf_packet_format_monitor (
  input wire        clk,
  input wire        reset_n,
  input wire        psel,
  input wire        penable,
  input wire        pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  input wire [31:0] prdata,
  input wire        pready,
  input wire        pslverr,
  input wire        manchester_on_ff,
  input wire        error_correction_on_ff,
  input wire        crc_on_ff,
  input wire [15:0] crc_poly_ff,
  input wire [15:0] tx_header_ff,
  input wire [7:0]  tx_payload_bytes_ff,
  input wire        tx_start_ff,
  input wire [11:0] rx_freq_offset_ff,
  input wire        phase_range_select_ff,
  input wire        offset_correction_domain_ff
);
  wire wr    = psel && penable && pwrite;
  wire w_opt = wr && paddr == `RPF_ADDR_PKT_OPT_A;
  wire w_cod = wr && paddr == `RPF_ADDR_PKT_CODING;
  wire w_txl = wr && paddr == `RPF_ADDR_TX_LEN;
  wire w_lo  = wr && paddr == `RPF_ADDR_FOFS_LO;
  wire w_mod = wr && paddr == `RPF_ADDR_OFS_PHASE;
  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);
  property p_ready_access; psel && !penable |=> pready; endproperty
  a_ready_access: assert property (p_ready_access) else $error("no ready in access cycle");
  property p_unmapped_err; psel && !penable && paddr > 12'h048 |=> pslverr && (pwrite || prdata == 32'h0); endproperty
  a_unmapped_err: assert property (p_unmapped_err) else $error("unmapped access not refused");
  property p_reserved_zero; pready && !pwrite |-> prdata[31:8] == 24'h0; endproperty
  a_reserved_zero: assert property (p_reserved_zero) else $error("upper read bits not zero");
  property p_tag_header; w_opt |-> ##2 tx_header_ff[15:14] == $past(pwdata[7:6], 2); endproperty
  a_tag_header: assert property (p_tag_header) else $error("header tag wrong");
  property p_coding;
    w_cod |-> ##2 {manchester_on_ff, error_correction_on_ff, crc_on_ff} == $past(pwdata[7:5], 2);
  endproperty
  a_coding: assert property (p_coding) else $error("coding enables wrong");
  property p_crc_poly; w_cod |-> ##2 crc_poly_ff == ($past(pwdata[4], 2) ? 16'h8005 : 16'h1021); endproperty
  a_crc_poly: assert property (p_crc_poly) else $error("crc polynomial wrong");
  property p_tx_len; w_txl |-> ##2 tx_payload_bytes_ff == $past(pwdata[7:0], 2); endproperty
  a_tx_len: assert property (p_tx_len) else $error("tx length wrong");
  property p_offset_hold; $changed(rx_freq_offset_ff) |-> $past(w_lo); endproperty
  a_offset_hold: assert property (p_offset_hold) else $error("offset changed without low write");
  property p_modes;
    w_mod |-> ##2 phase_range_select_ff == $past(pwdata[1], 2) && offset_correction_domain_ff == $past(pwdata[3], 2);
  endproperty
  a_modes: assert property (p_modes) else $error("demod modes wrong");
  property p_tx_pulse; tx_start_ff |=> !tx_start_ff; endproperty
  a_tx_pulse: assert property (p_tx_pulse) else $error("tx start longer than one cycle");
  c_low_write: cover property (w_lo);
  c_refused: cover property (pslverr);
  c_tx_start: cover property (tx_start_ff);
endmodule

bind rpf_packet_format rpf_packet_format_monitor u_mon (.*);

// File: rpf_far_model.sv
// Purpose: far end packet source that reports received packet fields
// Assumes: send is a one-cycle pulse, fields held until done
// Notes:   fields are inverted once done has passed so stale values never match
`timescale 1ns/1ps
module rpf_far_model (
  input  wire        clk,
  input  wire        reset_n,
  input  wire        send,
  input  wire [1:0]  m_tag,
  input  wire [5:0]  m_addr,
  input  wire [7:0]  m_ext,
  input  wire [7:0]  m_len,
  input  wire [3:0]  m_lag,
  output logic       rx_pkt_done,
  output wire [1:0]  rx_pkt_tag,
  output wire [5:0]  rx_pkt_addr,
  output wire [7:0]  rx_pkt_ext_addr,
  output wire [7:0]  rx_pkt_len,
  output logic [7:0] rx_fifo_count
);
  logic [23:0] fld_ff;
  logic [4:0]  cnt_ff;
  assign {rx_pkt_tag, rx_pkt_addr, rx_pkt_ext_addr, rx_pkt_len} = fld_ff;
  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      rx_pkt_done <= 1'b0;
      fld_ff <= 24'h0;
      cnt_ff <= 5'h0;
      rx_fifo_count <= 8'h0;
    end else begin
      rx_pkt_done <= 1'b0;
      if (rx_pkt_done) fld_ff <= ~fld_ff;
      if (send) cnt_ff <= {1'b0, m_lag} + 5'h1;
      else if (cnt_ff == 5'h1) begin
        rx_pkt_done <= 1'b1;
        fld_ff <= {m_tag, m_addr, m_ext, m_len};
        rx_fifo_count <= m_len;
        cnt_ff <= 5'h0;
      end else if (cnt_ff != 5'h0) cnt_ff <= cnt_ff - 5'h1;
    end
  end
endmodule

// File: rpf_packet_format_tb_top.sv
// Purpose: self-checking bench for the packet format register block
// Assumes: zero-wait apb slave, far model supplies received packets
// Notes:   reads are scored from a queue by a separate watcher
`timescale 1ns/1ps
`include "rpf_consts.vh"
module rpf_packet_format_tb_top;
  logic        clk = 1'b0, reset_n = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [11:0] paddr = 12'h0;
  logic [31:0] pwdata = 32'h0;
  logic        rx_enable_pulse = 1'b0, tx_request_pulse = 1'b0, send = 1'b0;
  logic [1:0]  m_tag = 2'h0;
  logic [5:0]  m_addr = 6'h0;
  logic [7:0]  m_ext = 8'h0, m_len = 8'h0, a, c, w, e, h, x, ln;
  logic [3:0]  m_lag = 4'h0;
  wire  [31:0] prdata;
  wire         pready, pslverr, rx_pkt_done, manchester_on_ff, error_correction_on_ff, crc_on_ff, trailer_on_ff;
  wire         scramble_on_ff, tx_header_two_bytes_ff, header_field_on_ff, rx_addr_fail_ff, rx_settled_ff, tx_start_ff;
  wire         phase_range_select_ff, offset_correction_domain_ff;
  wire  [1:0]  rx_pkt_tag, scramble_format_ff;
  wire  [3:0]  sync_size_ff;
  wire  [5:0]  rx_pkt_addr, demod_divider_ff, decimation_ratio_ff;
  wire  [7:0]  rx_pkt_ext_addr, rx_pkt_len, rx_fifo_count, tx_payload_bytes_ff, rx_expect_len_ff;
  wire  [8:0]  scramble_seed_ff, tx_bit_divider_ff;
  wire  [11:0] rx_freq_offset_ff;
  wire  [15:0] crc_poly_ff, tx_header_ff;
  logic [32:0] expq [$];
  int          n_fail = 0, n_checks = 0, nr, nt;
  int          settle_us [8] = '{4, 8, 12, 16, 20, 32, 64, 100};
  int          start_us [8] = '{0, 10, 20, 40, 60, 80, 100, 120};
  logic [7:0]  rst_tab [19] = '{8'h24, 8'h20, 8'h36, 8'h40, 8'h00, 8'h20, 8'h00, 8'h00, 8'h01, 8'h90,
                                8'h9a, 8'h03, 8'h00, 8'he0, 8'h08, 8'h30, 8'h40, 8'h00, 8'h00};
  rpf_packet_format dut (.*);
  rpf_far_model u_far (.*);
  always #10 clk = ~clk;
  task automatic report_and_stop();
    $display("checks %0d failures %0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  task automatic chk(input logic [32:0] got, input logic [32:0] exp);
    n_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  always @(posedge clk) begin
    if (pready === 1'b1 && psel && penable && !pwrite) chk({pslverr, prdata}, expq.pop_front());
  end
  task automatic xfer(input logic wd, input logic [11:0] ad, input logic [7:0] d, input logic [32:0] ex);
    int t;
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wd;
    paddr <= ad;
    pwdata <= {24'h0, d};
    @(posedge clk);
    penable <= 1'b1;
    if (!wd) expq.push_back(ex);
    t = 0;
    do begin
      @(posedge clk);
      t++;
    end while (pready !== 1'b1 && t < 50);
    if (t >= 50) chk(1'b0, 1'b1);
  endtask
  task automatic wr(input logic [11:0] ad, input logic [7:0] d);
    xfer(1'b1, ad, d, 33'h0);
  endtask
  task automatic rd(input logic [11:0] ad, input logic [7:0] ex);
    xfer(1'b0, ad, 8'h0, {25'h0, ex});
  endtask
  task automatic cyc(input int n);
    psel <= 1'b0;
    penable <= 1'b0;
    repeat (n) @(posedge clk);
  endtask
  task automatic pkt(input logic [1:0] tg, input logic [5:0] ad, input logic [7:0] l);
    int t;
    cyc(1);
    m_tag <= tg;
    m_addr <= ad;
    m_ext <= 8'h11;
    m_len <= l;
    m_lag <= 4'($urandom);
    send <= 1'b1;
    @(posedge clk);
    send <= 1'b0;
    t = 0;
    while (rx_pkt_done !== 1'b1 && t < 40) begin
      @(posedge clk);
      t++;
    end
    if (t >= 40) chk(1'b0, 1'b1);
    cyc(2);
  endtask
  initial begin
    #2000000;
    n_fail++;
    report_and_stop();
  end
  initial begin
    void'($urandom(32'h0b6d66f5));
    repeat (16) @(posedge clk);
    reset_n <= 1'b1;
    for (int i = 0; i < 19; i++) rd(12'(i * 4), rst_tab[i]);
    xfer(1'b0, 12'h04c, 8'h0, {1'b1, 32'h0});
    cyc(1);
    chk({sync_size_ff, trailer_on_ff, crc_on_ff, crc_poly_ff, tx_payload_bytes_ff}, {4'h3, 2'b11, 16'h1021, 8'h40});
    chk({tx_bit_divider_ff, rx_freq_offset_ff, demod_divider_ff}, {9'h001, 12'h99a, 6'h03});
    for (int k = 0; k < 8; k++) begin
      a = 8'($urandom); c = 8'($urandom); w = 8'($urandom); e = 8'($urandom) & 8'h0f;
      h = 8'($urandom); x = 8'($urandom); ln = 8'($urandom);
      wr(`RPF_ADDR_PKT_OPT_A, a); wr(`RPF_ADDR_PKT_CODING, c); wr(`RPF_ADDR_WHITEN_CTL, w); wr(`RPF_ADDR_EXT_CTL, e);
      wr(`RPF_ADDR_HDR_ADDR, h); wr(`RPF_ADDR_HDR_EXT_ADDR, x); wr(`RPF_ADDR_TX_LEN, ln);
      wr(`RPF_ADDR_DEMOD_DIV, h); wr(`RPF_ADDR_DECIM, ~h); wr(`RPF_ADDR_OFS_PHASE, x);
      cyc(2);
      chk(scramble_format_ff, {e[0], a[4]});
      chk(sync_size_ff, {1'b0, a[3:2], e[1]} + 4'h1);
      chk({manchester_on_ff, error_correction_on_ff, crc_on_ff, trailer_on_ff}, {c[7:5], a[5]});
      chk(crc_poly_ff, c[4] ? 16'h8005 : 16'h1021);
      chk({tx_header_two_bytes_ff, header_field_on_ff, tx_header_ff}, {c[1:0], a[7:6], h[5:0], c[1] ? x : 8'h0});
      chk({scramble_on_ff, scramble_seed_ff}, {w[7], e[3:2], w[6:0]});
      chk(tx_payload_bytes_ff, ln);
      chk({demod_divider_ff, decimation_ratio_ff, phase_range_select_ff, offset_correction_domain_ff},
          {h[5:0], ~h[5:0], x[1], x[3]});
      rd(`RPF_ADDR_PKT_OPT_A, a & 8'hfc);
      rd(`RPF_ADDR_OFS_PHASE, x & 8'h0a);
    end
    wr(`RPF_ADDR_RATE_DIV_LO, 8'h23); wr(`RPF_ADDR_FOFS_HI, 8'h51);
    cyc(2);
    chk({tx_bit_divider_ff, rx_freq_offset_ff}, {9'h123, 12'h99a});
    wr(`RPF_ADDR_FOFS_LO, 8'h34);
    cyc(2);
    chk(rx_freq_offset_ff, 12'h534);
    wr(`RPF_ADDR_RX_ID_DLY, 8'hff); rd(`RPF_ADDR_RX_ID_DLY, 8'h3f);
    wr(`RPF_ADDR_RX_LEN, 8'h33); wr(`RPF_ADDR_PKT_CODING, 8'h04); wr(`RPF_ADDR_HDR_ADDR, 8'h05);
    pkt(2'h2, 6'h05, 8'h09);
    chk({rx_addr_fail_ff, rx_expect_len_ff}, {1'b0, 8'h33});
    rd(`RPF_ADDR_RX_ID_DLY, 8'hbf); rd(`RPF_ADDR_HDR_ADDR, 8'h05); rd(`RPF_ADDR_RX_LEN, 8'h09);
    pkt(2'h1, 6'h06, 8'h09);
    chk(rx_addr_fail_ff, 1'b1);
    wr(`RPF_ADDR_HDR_ADDR, 8'h00);
    pkt(2'h1, 6'h06, 8'h09);
    chk(rx_addr_fail_ff, 1'b0);
    wr(`RPF_ADDR_HDR_ADDR, 8'h05); wr(`RPF_ADDR_PKT_CODING, 8'h08);
    pkt(2'h3, 6'h06, 8'h21);
    chk({rx_addr_fail_ff, rx_expect_len_ff}, {1'b0, 8'h21});
    for (int i = 0; i < 8; i++) begin
      wr(`RPF_ADDR_RX_ID_DLY, {2'b00, 3'(i), 3'(i)});
      cyc(1);
      rx_enable_pulse <= 1'b1;
      tx_request_pulse <= 1'b1;
      @(posedge clk);
      rx_enable_pulse <= 1'b0;
      tx_request_pulse <= 1'b0;
      fork
        begin
          nr = 0;
          do begin @(posedge clk); nr++; end while (rx_settled_ff !== 1'b1 && nr < 7000);
        end
        begin
          nt = 0;
          do begin @(posedge clk); nt++; end while (tx_start_ff !== 1'b1 && nt < 7000);
        end
      join
      chk(nr, settle_us[i] * `RPF_CLK_MHZ + 3);
      chk(nt, start_us[i] * `RPF_CLK_MHZ + 3);
    end
    report_and_stop();
  end
endmodule
